// >>> core/mode_pin_config.sv
// mode-pin configuration and power-down control with an apb register port
// assumes pins and apb are synchronous to CLK_SYS; RST_B is synchronous, active low
`timescale 1ns/1ps
module mode_pin_config (
    input wire logic CLK_SYS,
    input wire logic RST_B,
    input wire logic SERIAL_PORT_SELECT,
    input wire logic SERIAL_DATA_IO_PIN,
    input wire logic SERIAL_CLOCK_PIN,
    input wire logic SERIAL_DATA_OUT_PIN,
    input wire logic FLEX_CONTROL_PIN_ONE,
    input wire logic FLEX_CONTROL_PIN_TWO,
    input wire logic ADC_LOW_POWER_STRAP,
    input wire logic RX_POWERDOWN_PIN,
    input wire logic TX_POWERDOWN_PIN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic SERIAL_PORT_EN,
    output logic [1:0] DUPLEX_MODE,
    output logic [1:0] INTERP_SEL,
    output logic [1:0] PLL_MULT_SEL,
    output logic ADC_LOW_POWER_EN,
    output logic RX_CLK_EN,
    output logic TX_CLK_EN,
    output logic RX_ANALOG_EN,
    output logic TX_ANALOG_EN,
    output logic RX_ANALOG_READY,
    output logic TX_ANALOG_READY,
    output logic PLL_EN
);

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic cfg_full;
        logic cfg_il;
        logic [1:0] cfg_interp;
        logic serial_en;
        strap_pkg::duplex_mode_e mode;
        logic [1:0] interp;
        logic [1:0] pll;
        logic adc_lp;
        logic rx_clk;
        logic tx_clk;
        logic rx_an;
        logic tx_an;
        logic pll_en;
        logic [1:0] ready;
        logic [1:0][strap_pkg::CNT_W-1:0] cnt;
    } state_s;

    localparam logic [strap_pkg::CNT_W-1:0] RESTART_CNT =
        strap_pkg::CNT_W'(strap_pkg::RESTART_CYCLES);

    state_s st_r;
    state_s st_nxt;
    strap_if straps ();

    // effective configuration and live gating terms
    logic eff_full;
    logic eff_il;
    logic [1:0] eff_code;
    logic [1:0] eff_interp;
    strap_pkg::duplex_mode_e eff_mode;
    logic rx_dir_ok;
    logic tx_dir_ok;
    logic [1:0] an_en;
    logic [1:0][strap_pkg::CNT_W-1:0] cnt_nxt;
    logic [1:0] rdy_nxt;
    logic bad_code;
    logic bad_combo;
    logic apb_access;
    logic [31:0] status_word;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // maps a two-bit interpolation code to a legal factor, reserved code to 1x
    function automatic logic [1:0] interp_decode(input logic [1:0] code);
        case (code)
            strap_pkg::INTERP_2X: interp_decode = strap_pkg::INTERP_2X;
            strap_pkg::INTERP_4X: interp_decode = strap_pkg::INTERP_4X;
            default: interp_decode = strap_pkg::INTERP_1X;
        endcase
    endfunction

    // true for a word-aligned register offset that exists
    function automatic logic addr_mapped(input logic [7:0] addr);
        addr_mapped = (addr == strap_pkg::ADDR_STATUS) || (addr == strap_pkg::ADDR_SERIAL_CFG);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // strap capture stage

    strap_capture u_capture (
        .clk(CLK_SYS),
        .rst_b(RST_B),
        .serial_select(SERIAL_PORT_SELECT),
        .serial_data_io(SERIAL_DATA_IO_PIN),
        .serial_clock(SERIAL_CLOCK_PIN),
        .serial_data_out(SERIAL_DATA_OUT_PIN),
        .flex_control_two(FLEX_CONTROL_PIN_TWO),
        .adc_low_power(ADC_LOW_POWER_STRAP),
        .straps(straps.cap)
    );

    ////////////////////////////////////////////////////////////////////////
    // effective mode: registers replace straps while the serial port is on

    always_comb begin
        if (straps.serial_en) begin
            eff_full = st_r.cfg_full;
            eff_il = st_r.cfg_il;
            eff_code = st_r.cfg_interp;
        end else begin
            eff_full = straps.duplex_hi;
            eff_il = straps.width_hi;
            eff_code = straps.interp;
        end
        if (eff_full) begin
            eff_mode = strap_pkg::MODE_FULL;
        end else if (eff_il) begin
            eff_mode = strap_pkg::MODE_HALF_INTERLEAVED;
        end else begin
            eff_mode = strap_pkg::MODE_HALF_PARALLEL;
        end
        eff_interp = interp_decode(eff_code);
        bad_code = (eff_code != eff_interp);
        bad_combo = (eff_mode != strap_pkg::MODE_HALF_PARALLEL)
            && (eff_interp == strap_pkg::INTERP_1X);
    end

    // direction pin only matters in half duplex
    assign rx_dir_ok = eff_full || !FLEX_CONTROL_PIN_ONE;
    assign tx_dir_ok = eff_full || FLEX_CONTROL_PIN_ONE;

    // analog blocks follow only the power-down pins, not the direction pin
    assign an_en[0] = straps.valid && !RX_POWERDOWN_PIN;
    assign an_en[1] = straps.valid && !TX_POWERDOWN_PIN;

    ////////////////////////////////////////////////////////////////////////
    // per-path analog restart timers, index 0 receive and 1 transmit

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_restart
            always_comb begin
                if (!an_en[gi]) begin
                    cnt_nxt[gi] = '0;
                end else if (st_r.cnt[gi] != RESTART_CNT) begin
                    cnt_nxt[gi] = st_r.cnt[gi] + 1'b1;
                end else begin
                    cnt_nxt[gi] = st_r.cnt[gi];
                end
                rdy_nxt[gi] = an_en[gi] && (cnt_nxt[gi] == RESTART_CNT);
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // status word assembly

    always_comb begin
        status_word = '0;
        status_word[strap_pkg::ST_SERIAL_BIT] = st_r.serial_en;
        status_word[strap_pkg::ST_FULL_BIT] = eff_full;
        status_word[strap_pkg::ST_IL_BIT] = eff_il;
        status_word[strap_pkg::ST_INTERP_LSB +: 2] = eff_interp;
        status_word[strap_pkg::ST_ADC_LP_BIT] = st_r.adc_lp;
        status_word[strap_pkg::ST_RX_CLK_BIT] = st_r.rx_clk;
        status_word[strap_pkg::ST_TX_CLK_BIT] = st_r.tx_clk;
        status_word[strap_pkg::ST_RX_RDY_BIT] = st_r.ready[0];
        status_word[strap_pkg::ST_TX_RDY_BIT] = st_r.ready[1];
        status_word[strap_pkg::ST_BAD_CODE_BIT] = bad_code;
        status_word[strap_pkg::ST_BAD_COMBO_BIT] = bad_combo;
        status_word[strap_pkg::ST_VALID_BIT] = straps.valid;
    end

    assign apb_access = PSEL && PENABLE;

    ////////////////////////////////////////////////////////////////////////
    // next state: apb slave and registered control outputs

    always_comb begin
        st_nxt = st_r;
        // one wait state, answer on the second access cycle
        st_nxt.pready = apb_access && !st_r.pready;
        st_nxt.pslverr = 1'b0;
        if (apb_access && !st_r.pready) begin
            st_nxt.pslverr = !addr_mapped(PADDR);
            st_nxt.prdata = '0;
            if (!PWRITE && PADDR == strap_pkg::ADDR_STATUS) begin
                st_nxt.prdata = status_word;
            end else if (!PWRITE && PADDR == strap_pkg::ADDR_SERIAL_CFG) begin
                st_nxt.prdata[strap_pkg::CFG_FULL_BIT] = st_r.cfg_full;
                st_nxt.prdata[strap_pkg::CFG_IL_BIT] = st_r.cfg_il;
                st_nxt.prdata[strap_pkg::CFG_INTERP_LSB +: 2] = st_r.cfg_interp;
            end
        end
        // a write lands on the edge that completes the transfer
        if (apb_access && st_r.pready && PWRITE && PADDR == strap_pkg::ADDR_SERIAL_CFG) begin
            st_nxt.cfg_full = PWDATA[strap_pkg::CFG_FULL_BIT];
            st_nxt.cfg_il = PWDATA[strap_pkg::CFG_IL_BIT];
            st_nxt.cfg_interp = PWDATA[strap_pkg::CFG_INTERP_LSB +: 2];
        end
        // configuration outputs stay idle until straps are captured
        st_nxt.serial_en = straps.serial_en;
        st_nxt.mode = straps.valid ? eff_mode : strap_pkg::MODE_HALF_PARALLEL;
        st_nxt.interp = straps.valid ? eff_interp : strap_pkg::INTERP_1X;
        st_nxt.pll = straps.valid ? eff_interp : strap_pkg::INTERP_1X;
        st_nxt.adc_lp = straps.adc_lp;
        // live gating from the power-down and direction pins
        st_nxt.rx_clk = an_en[0] && rx_dir_ok;
        st_nxt.tx_clk = an_en[1] && tx_dir_ok;
        st_nxt.rx_an = an_en[0];
        st_nxt.tx_an = an_en[1];
        st_nxt.pll_en = straps.valid;
        st_nxt.cnt = cnt_nxt;
        st_nxt.ready = rdy_nxt;
    end

    // single state register
    always_ff @(posedge CLK_SYS) begin
        if (!RST_B) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs straight from the state register

    assign PRDATA = st_r.prdata;
    assign PREADY = st_r.pready;
    assign PSLVERR = st_r.pslverr;
    assign SERIAL_PORT_EN = st_r.serial_en;
    assign DUPLEX_MODE = st_r.mode;
    assign INTERP_SEL = st_r.interp;
    assign PLL_MULT_SEL = st_r.pll;
    assign ADC_LOW_POWER_EN = st_r.adc_lp;
    assign RX_CLK_EN = st_r.rx_clk;
    assign TX_CLK_EN = st_r.tx_clk;
    assign RX_ANALOG_EN = st_r.rx_an;
    assign TX_ANALOG_EN = st_r.tx_an;
    assign RX_ANALOG_READY = st_r.ready[0];
    assign TX_ANALOG_READY = st_r.ready[1];
    assign PLL_EN = st_r.pll_en;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RST_B);

    serial_follow_a: assert property (
        straps.valid |=> SERIAL_PORT_EN == $past(straps.serial_en))
        else $error("serial port enable does not follow strap");

    serial_override_a: assert property (
        straps.valid && straps.serial_en && st_r.cfg_full
        |=> DUPLEX_MODE == strap_pkg::MODE_FULL)
        else $error("register duplex setting ignored in serial mode");

    half_duplex_a: assert property (
        straps.valid && !straps.serial_en && !straps.duplex_hi && !straps.width_hi
        |=> DUPLEX_MODE == strap_pkg::MODE_HALF_PARALLEL)
        else $error("half duplex parallel not selected");

    interleave_sel_a: assert property (
        straps.valid && !straps.serial_en && !straps.duplex_hi && straps.width_hi
        |=> DUPLEX_MODE == strap_pkg::MODE_HALF_INTERLEAVED)
        else $error("half duplex interleaved not selected");

    interp_pll_a: assert property (
        straps.valid && !straps.serial_en && straps.interp == strap_pkg::INTERP_4X
        |=> INTERP_SEL == strap_pkg::INTERP_4X && PLL_MULT_SEL == strap_pkg::INTERP_4X)
        else $error("interpolation or pll factor wrong");

    adc_power_a: assert property (
        straps.valid |=> ADC_LOW_POWER_EN == $past(straps.adc_lp))
        else $error("adc low power does not follow strap");

    rx_powerdown_a: assert property (
        RX_POWERDOWN_PIN |=> !RX_CLK_EN && !RX_ANALOG_EN && !RX_ANALOG_READY)
        else $error("receive path active while powered down");

    tx_powerdown_a: assert property (
        straps.valid && TX_POWERDOWN_PIN |=> !TX_CLK_EN && !TX_ANALOG_EN && PLL_EN)
        else $error("transmit power-down wrong or pll off");

    direction_gate_a: assert property (
        straps.valid && !eff_full && FLEX_CONTROL_PIN_ONE && !TX_POWERDOWN_PIN
        |=> TX_CLK_EN && !RX_CLK_EN)
        else $error("direction pin does not select transmit");

    direction_analog_a: assert property (
        straps.valid && !eff_full && !RX_POWERDOWN_PIN && FLEX_CONTROL_PIN_ONE
        |=> RX_ANALOG_EN && !RX_CLK_EN && PLL_EN)
        else $error("direction pin touched analog or pll");

    // receive direction must leave transmit analog and the pll running
    tx_analog_keep_a: assert property (
        straps.valid && !eff_full && !TX_POWERDOWN_PIN && !FLEX_CONTROL_PIN_ONE
        |=> TX_ANALOG_EN && !TX_CLK_EN && PLL_EN)
        else $error("receive direction touched transmit analog or pll");

    // ready must not come with the first powered cycle
    rx_restart_a: assert property (
        $rose(RX_ANALOG_EN) |-> !RX_ANALOG_READY)
        else $error("receive ready before the restart time");

    // unmapped offsets answer with an error and zero data
    bad_addr_a: assert property (
        PSEL && PENABLE && !PREADY && !addr_mapped(PADDR)
        |=> PREADY && PSLVERR && PRDATA == 32'h0)
        else $error("unmapped offset not refused");

    apb_wait_a: assert property (
        PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY)
        else $error("apb answer not after one wait state");

endmodule // mode_pin_config

// >>> core/strap_pkg.sv
// constants, types and register layout for the mode-pin configuration block
// assumes a 20 mhz system clock and a 32-bit apb register port
package strap_pkg;

    // apb register byte offsets
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_SERIAL_CFG = 8'h04;

    // serial configuration register fields
    localparam int CFG_FULL_BIT = 0;
    localparam int CFG_IL_BIT = 1;
    localparam int CFG_INTERP_LSB = 2;
    localparam logic [31:0] CFG_RESET = 32'h0000_0000;

    // status register fields
    localparam int ST_SERIAL_BIT = 0;
    localparam int ST_FULL_BIT = 1;
    localparam int ST_IL_BIT = 2;
    localparam int ST_INTERP_LSB = 3;
    localparam int ST_ADC_LP_BIT = 5;
    localparam int ST_RX_CLK_BIT = 6;
    localparam int ST_TX_CLK_BIT = 7;
    localparam int ST_RX_RDY_BIT = 8;
    localparam int ST_TX_RDY_BIT = 9;
    localparam int ST_BAD_CODE_BIT = 10;
    localparam int ST_BAD_COMBO_BIT = 11;
    localparam int ST_VALID_BIT = 12;

    // interpolation and pll factor codes
    localparam logic [1:0] INTERP_1X = 2'h0;
    localparam logic [1:0] INTERP_2X = 2'h1;
    localparam logic [1:0] INTERP_4X = 2'h2;

    // analog restart time and its count at the system clock rate
    localparam int CLK_PERIOD_NS = 50;
    localparam int RESTART_TIME_US = 10;
    localparam int RESTART_CYCLES = (RESTART_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;

    // flexible data port operating modes
    typedef enum logic [1:0] {
        MODE_HALF_PARALLEL,
        MODE_HALF_INTERLEAVED,
        MODE_FULL
    } duplex_mode_e;

endpackage

// >>> core/strap_if.sv
// carries the captured power-up straps from the capture stage to the control logic
// assumes both ends run on the same system clock
`timescale 1ns/1ps
interface strap_if;
    logic valid;
    logic serial_en;
    logic duplex_hi;
    logic width_hi;
    logic [1:0] interp;
    logic adc_lp;

    modport cap (output valid, output serial_en, output duplex_hi, output width_hi,
        output interp, output adc_lp);
    modport use_side (input valid, input serial_en, input duplex_hi, input width_hi,
        input interp, input adc_lp);
endinterface

// >>> core/strap_capture.sv
// latches the configuration straps once, on the first clock after reset release
// assumes strap pins are synchronous to clk and steady around reset release
`timescale 1ns/1ps
module strap_capture (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic serial_select,
    input wire logic serial_data_io,
    input wire logic serial_clock,
    input wire logic serial_data_out,
    input wire logic flex_control_two,
    input wire logic adc_low_power,
    strap_if.cap straps
);

    typedef struct packed {
        logic armed;
        logic valid;
        logic serial_en;
        logic duplex_hi;
        logic width_hi;
        logic [1:0] interp;
        logic adc_lp;
    } cap_s;

    cap_s st_r;
    cap_s st_nxt;

    ////////////////////////////////////////////////////////////////////////
    // capture on the release edge, then hold until the next reset
    always_comb begin
        st_nxt = st_r;
        if (st_r.armed) begin
            st_nxt.armed = 1'b0;
            st_nxt.valid = 1'b1;
            st_nxt.serial_en = serial_select;
            st_nxt.duplex_hi = serial_data_out;
            st_nxt.width_hi = flex_control_two;
            st_nxt.interp = {serial_data_io, serial_clock};
            st_nxt.adc_lp = adc_low_power;
        end
    end

    // reset arms the capture and clears the latched straps
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_r <= '0;
            st_r.armed <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign straps.valid = st_r.valid;
    assign straps.serial_en = st_r.serial_en;
    assign straps.duplex_hi = st_r.duplex_hi;
    assign straps.width_hi = st_r.width_hi;
    assign straps.interp = st_r.interp;
    assign straps.adc_lp = st_r.adc_lp;

    ////////////////////////////////////////////////////////////////////////
    // capture takes the pin levels seen at the release edge
    strap_latch_a: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(st_r.valid) |-> st_r.serial_en == $past(serial_select)
            && st_r.duplex_hi == $past(serial_data_out)
            && st_r.interp == $past({serial_data_io, serial_clock}))
        else $error("straps not taken at reset release");

    strap_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
        $past(st_r.valid) |-> $stable({st_r.serial_en, st_r.duplex_hi, st_r.width_hi,
            st_r.interp, st_r.adc_lp}))
        else $error("captured straps changed after capture");

endmodule // strap_capture

// >>> bench/strap_board.sv
// board-side model: drives the strap pins and the live power-down and direction pins
// assumes one system clock; straps are meaningful only around reset release
`timescale 1ns/1ps
module strap_board (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [5:0] cfg,
    input wire logic rx_pd,
    input wire logic tx_pd,
    input wire logic dir,
    output logic sel,
    output logic dio,
    output logic sclk,
    output logic dout,
    output logic f1,
    output logic f2,
    output logic adc,
    output logic rxp,
    output logic txp
);
    logic [1:0] settle_r;
    logic flip_r;

    ////////////////////////////////////////////////////////////////////////////////
    // count edges after release; live pins change just after an edge
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            settle_r <= 2'h0;
            flip_r <= 1'b0;
        end else begin
            if (settle_r != 2'h3) settle_r <= settle_r + 2'h1;
            flip_r <= ~flip_r;
        end
        rxp <= rx_pd;
        txp <= tx_pd;
        f1 <= dir;
    end

    // straps held through release, select low unless serial wanted
    // then scrambled every other cycle so a late sample shows up
    assign {sel, dio, sclk, dout, f2, adc} = (settle_r == 2'h3) ? (~cfg ^ {6{flip_r}}) : cfg;
endmodule // strap_board

// >>> bench/tb_mode_pin_config.sv
// self-checking bench for the mode-pin configuration block
// assumes the board model drives all pins and the bench is the apb master
`timescale 1ns/1ps
module tb_mode_pin_config;
    logic CLK_SYS = 1'b0, RST_B = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0, PRDATA, rd;
    logic PREADY, PSLVERR, SERIAL_PORT_EN, ADC_LOW_POWER_EN, PLL_EN, err;
    logic [1:0] DUPLEX_MODE, INTERP_SEL, PLL_MULT_SEL;
    logic RX_CLK_EN, TX_CLK_EN, RX_ANALOG_EN, TX_ANALOG_EN, RX_ANALOG_READY, TX_ANALOG_READY;
    logic sel, dio, sclk, dout, f1, f2, adc, rxp, txp, rx_pd = 1'b0, tx_pd = 1'b0, dir = 1'b0;
    logic [5:0] cfg = 6'h00;
    logic [3:0] mi;
    int mismatches = 0, samples_checked = 0;
    // 6'h0b and 6'h14 pick 2x interleaved and 4x full, only 6'h1e probes the error flags
    localparam logic [5:0] CFGS [5] = '{6'h00, 6'h0b, 6'h14, 6'h1e, 6'h3f};

    always #25 CLK_SYS = ~CLK_SYS;

    strap_board i_board (.clk(CLK_SYS), .rst_b(RST_B), .cfg(cfg), .rx_pd(rx_pd), .tx_pd(tx_pd),
        .dir(dir), .sel(sel), .dio(dio), .sclk(sclk), .dout(dout), .f1(f1), .f2(f2), .adc(adc),
        .rxp(rxp), .txp(txp));
    mode_pin_config i_dut (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .SERIAL_PORT_SELECT(sel),
        .SERIAL_DATA_IO_PIN(dio), .SERIAL_CLOCK_PIN(sclk), .SERIAL_DATA_OUT_PIN(dout),
        .FLEX_CONTROL_PIN_ONE(f1), .FLEX_CONTROL_PIN_TWO(f2), .ADC_LOW_POWER_STRAP(adc),
        .RX_POWERDOWN_PIN(rxp), .TX_POWERDOWN_PIN(txp), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .SERIAL_PORT_EN(SERIAL_PORT_EN), .DUPLEX_MODE(DUPLEX_MODE),
        .INTERP_SEL(INTERP_SEL), .PLL_MULT_SEL(PLL_MULT_SEL), .ADC_LOW_POWER_EN(ADC_LOW_POWER_EN),
        .RX_CLK_EN(RX_CLK_EN), .TX_CLK_EN(TX_CLK_EN), .RX_ANALOG_EN(RX_ANALOG_EN),
        .TX_ANALOG_EN(TX_ANALOG_EN), .RX_ANALOG_READY(RX_ANALOG_READY),
        .TX_ANALOG_READY(TX_ANALOG_READY), .PLL_EN(PLL_EN));

    ////////////////////////////////////////////////////////////////////////////////
    // compare, report and finish
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic test_done();
        if (mismatches == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge CLK_SYS);
        PSEL <= 1'b1; PENABLE <= 1'b0; PWRITE <= wr; PADDR <= a; PWDATA <= wd;
        @(posedge CLK_SYS);
        PENABLE <= 1'b1;
        do begin @(posedge CLK_SYS); n++; end while (PREADY !== 1'b1 && n < 20);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0; PENABLE <= 1'b0;
        if (n >= 20) begin
            check("pready", 32'h0, 32'h1);
            test_done();
        end
    endtask

    // reset with a strap set, held two cycles
    task automatic do_reset(input logic [5:0] c);
        @(posedge CLK_SYS);
        RST_B <= 1'b0; cfg <= c;
        repeat (2) @(posedge CLK_SYS);
        RST_B <= 1'b1;
        repeat (6) @(posedge CLK_SYS);
    endtask

    // expected {mode, interp} for a strap set; serial mode uses register defaults
    function automatic logic [3:0] exp_mi(input logic [5:0] c);
        logic [1:0] m;
        m = c[2] ? 2'h2 : (c[1] ? 2'h1 : 2'h0);
        if (c[5]) return 4'h0;
        return {m, (c[4:3] == 2'h3) ? 2'h0 : c[4:3]};
    endfunction

    // sweep all live pin combinations and compare the enables
    task automatic live_sweep(input logic full);
        for (int p = 0; p < 8; p++) begin
            @(posedge CLK_SYS);
            {rx_pd, tx_pd, dir} <= p[2:0];
            repeat (4) @(posedge CLK_SYS);
            check("enables", {RX_CLK_EN, TX_CLK_EN, RX_ANALOG_EN, TX_ANALOG_EN, PLL_EN},
                {!p[2] && (full || !p[0]), !p[1] && (full || p[0]),
                !p[2], !p[1], 1'b1});
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge CLK_SYS);
        mismatches++;
        test_done();
    end

    initial begin
        repeat (2) @(posedge CLK_SYS);
        RST_B <= 1'b1;
        foreach (CFGS[i]) begin
            do_reset(CFGS[i]);
            mi = exp_mi(CFGS[i]);
            for (int j = 0; j < 2; j++) begin
                repeat (3) @(posedge CLK_SYS);
                check("serial_en", SERIAL_PORT_EN, CFGS[i][5]);
                check("duplex", DUPLEX_MODE, mi[3:2]);
                check("interp", {INTERP_SEL, PLL_MULT_SEL}, {2{mi[1:0]}});
                check("adc_lp", ADC_LOW_POWER_EN, CFGS[i][0]);
            end
            apb(1'b0, strap_pkg::ADDR_STATUS, 32'h0);
            check("status", {rd[12:10], rd[5:0]}, {1'b1, mi[1:0] == 2'h0 && mi[3:2] != 2'h0,
                !CFGS[i][5] && CFGS[i][4:3] == 2'h3, CFGS[i][0], mi[1:0],
                !CFGS[i][5] && CFGS[i][1], mi[3:2] == 2'h2, CFGS[i][5]});
        end
        // serial port on: registers replace duplex and interpolation straps
        apb(1'b0, strap_pkg::ADDR_SERIAL_CFG, 32'h0);
        check("cfg_reset", rd, strap_pkg::CFG_RESET);
        apb(1'b1, strap_pkg::ADDR_SERIAL_CFG, 32'h9);
        apb(1'b1, strap_pkg::ADDR_STATUS, 32'hffff_ffff);
        apb(1'b0, strap_pkg::ADDR_SERIAL_CFG, 32'h0);
        check("cfg_read", {rd, err}, {32'h9, 1'b0});
        check("reg_modes", {DUPLEX_MODE, INTERP_SEL, PLL_MULT_SEL}, 6'h2a);
        apb(1'b0, 8'h08, 32'h0);
        check("unmapped", {rd, err}, {32'h0, 1'b1});
        apb(1'b0, 8'h05, 32'h0);
        check("misaligned", {rd, err}, {32'h0, 1'b1});
        apb(1'b0, strap_pkg::ADDR_STATUS, 32'h0);
        check("status_ro", rd[4:0], 5'h13);
        // half duplex interleaved, then full duplex: live controls
        do_reset(6'h0b);
        live_sweep(1'b0);
        @(posedge CLK_SYS);
        {rx_pd, tx_pd, dir} <= 3'h4;
        repeat (10) @(posedge CLK_SYS);
        rx_pd <= 1'b0;
        repeat (strap_pkg::RESTART_CYCLES - 20) @(posedge CLK_SYS);
        check("rx_ready_early", RX_ANALOG_READY, 1'b0);
        repeat (30) @(posedge CLK_SYS);
        check("rx_ready", {RX_ANALOG_READY, TX_ANALOG_READY}, 2'h3);
        do_reset(6'h14);
        live_sweep(1'b1);
        test_done();
    end
endmodule // tb_mode_pin_config
